// *** rtl/gdis_pkg.sv ***
// Purpose: Shared constants and state type of the port and DMA event block
// Assumes: AXI4-Lite word per register, index times four is the byte address
// Notes:   Indices mirror the printed register offsets

package gdis_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W  = 7;
  localparam int IDX_LSB = 2;
  localparam int PIN_W   = 11;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Register indices
  // ----------------------------------------------------------------
  localparam logic [4:0] IDX_GSTAT   = 5'h03;
  localparam logic [4:0] IDX_PMASK_L = 5'h08;
  localparam logic [4:0] IDX_PMASK_H = 5'h09;
  localparam logic [4:0] IDX_PEV_L   = 5'h0a;
  localparam logic [4:0] IDX_PEV_H   = 5'h0b;
  localparam logic [4:0] IDX_CMD     = 5'h0c;
  localparam logic [4:0] IDX_DSTAT   = 5'h0e;
  localparam logic [4:0] IDX_DMASK   = 5'h0f;
  localparam logic [4:0] IDX_RXSZ_A  = 5'h10;
  localparam logic [4:0] IDX_RXSZ_B  = 5'h11;
  localparam logic [4:0] IDX_TXBC_A  = 5'h12;
  localparam logic [4:0] IDX_TXBC_B  = 5'h13;
  localparam logic [4:0] IDX_CFG     = 5'h14;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int GS_PORT     = 7;
  localparam int GS_DMA      = 6;
  localparam int CH_STRIDE   = 4;
  localparam int ST_TX_END   = 0;
  localparam int ST_RX_END   = 1;
  localparam int ST_RX_FULL  = 2;
  localparam int CMD_RX      = 1;
  localparam int CMD_TX      = 3;
  localparam int CFG_CHK_DIS = 0;

  // ----------------------------------------------------------------
  // Masks and reset values
  // ----------------------------------------------------------------
  localparam logic [10:0] PIN_VALID = 11'h747;
  localparam logic [10:0] RST_PMASK = 11'h747;
  localparam logic [7:0]  RST_DMASK = 8'h77;
  localparam logic [7:0]  DMASK_BITS = 8'h77;
  localparam logic [7:0]  CMD_BITS  = 8'haa;

  typedef struct packed {
    logic             awrdy;
    logic             wrdy;
    logic             bval;
    logic [1:0]       bresp;
    logic             aw_have;
    logic             w_have;
    logic [4:0]       widx;
    logic [31:0]      wdat;
    logic [3:0]       wstb;
    logic             arrdy;
    logic             rval;
    logic [1:0]       rresp;
    logic [31:0]      rdat;
    logic             primed;
    logic [10:0]      pin_prev;
    logic [10:0]      port_flag;
    logic [10:0]      port_mask;
    logic [7:0]       dma_stat;
    logic [7:0]       dma_mask;
    logic [7:0]       cmd;
    logic             chk_dis;
    logic [1:0][15:0] rx_size;
    logic [1:0][15:0] tx_total;
    logic [1:0][15:0] rx_cnt;
    logic [1:0][15:0] tx_cnt;
    logic             irq;
  } gdis_state_t;

  localparam gdis_state_t ST_RST = '{
    awrdy: 1'b1, wrdy: 1'b1, arrdy: 1'b1,
    port_mask: RST_PMASK, dma_mask: RST_DMASK, default: '0};

endpackage

// *** rtl/gdis_top.sv ***
// Purpose: Port transition events and DMA support events with read-clear status
// Assumes: All inputs synchronous to clk, AXI4-Lite register access
// Notes:   Interrupt request is a registered level
//
// Function
// - Pin transition sets its event flag
// - Reading port status clears its flags
// - Low port status: pins 10..8, bits 2..0
// - High port status: pins 6,2,1,0
// - Zero command bit leaves path alone
// - DMA status layout, bits 7 and 3 zero
// - DMA events recorded even when masked
// - Unmasking a pending event raises interrupt
// - Buffer size reached raises buffer-full event
// - Check disable suppresses buffer-full event
// - Last receive byte moved raises end
// - Transmit count reached raises transmit end
// - Mask bit one blocks event interrupt
// - DMA mask resets with all masked
// - Port mask one disables pin events
// - Global status shows DMA pending summary
// - Global status shows port pending summary

`timescale 1ns/10ps
`default_nettype none

module gdis_top
  import gdis_pkg::*;
(
  // Clock, reset, enable
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              ce,
  // AXI4-Lite write address and data
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  // AXI4-Lite write response
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // Port pins
  input  wire logic [PIN_W-1:0]  gpp_pin_in,
  // DMA support, index 0 channel A, 1 channel B
  input  wire logic [1:0]        rx_dma_ack,
  input  wire logic [1:0]        rx_dma_last,
  input  wire logic [1:0]        tx_dma_ack,
  output logic [1:0]             rx_path_reset,
  output logic [1:0]             tx_path_reset,
  // Interrupt request
  output logic                   irq
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic is_map(input logic [4:0] i);
    case (i)
      IDX_GSTAT, IDX_PMASK_L, IDX_PMASK_H, IDX_PEV_L, IDX_PEV_H,
      IDX_CMD, IDX_DSTAT, IDX_DMASK, IDX_RXSZ_A, IDX_RXSZ_B,
      IDX_TXBC_A, IDX_TXBC_B, IDX_CFG: is_map = 1'b1;
      default: is_map = 1'b0;
    endcase
  endfunction

  function automatic logic [15:0] lane16(input logic [15:0] old,
                                         input logic [15:0] nw,
                                         input logic [1:0]  stb);
    lane16 = old;
    if (stb[0]) begin
      lane16[7:0] = nw[7:0];
    end
    if (stb[1]) begin
      lane16[15:8] = nw[15:8];
    end
  endfunction

  gdis_state_t q;
  gdis_state_t d;

  logic [4:0]       ridx;
  logic             ar_hs;
  logic             aw_hs;
  logic             w_hs;
  logic             do_wr;
  logic [PIN_W-1:0] port_ev;
  logic [7:0]       dma_ev;
  logic [1:0]       rx_full_hit;
  logic [1:0]       tx_end_hit;
  logic             dma_any;
  logic             port_any;

  assign ridx     = araddr[ADDR_W-1:IDX_LSB];
  assign ar_hs    = arvalid && q.arrdy;
  assign aw_hs    = awvalid && q.awrdy;
  assign w_hs     = wvalid && q.wrdy;
  assign do_wr    = q.aw_have && q.w_have && !q.bval;
  assign dma_any  = |q.dma_stat;
  assign port_any = |q.port_flag;

  // ----------------------------------------------------------------
  // Event detection
  // ----------------------------------------------------------------
  // Unmasked transitions
  assign port_ev = q.primed ?
                   ((gpp_pin_in ^ q.pin_prev) & ~q.port_mask & PIN_VALID) : '0;

  for (genvar c = 0; c < 2; c++) begin : g_ch
    assign rx_full_hit[c] = rx_dma_ack[c] && !q.chk_dis &&
                            (q.rx_size[c] != 16'h0000) &&
                            (q.rx_cnt[c] + 16'h0001 == q.rx_size[c]);
    assign tx_end_hit[c]  = tx_dma_ack[c] && (q.tx_total[c] != 16'h0000) &&
                            (q.tx_cnt[c] + 16'h0001 == q.tx_total[c]);
    assign dma_ev[CH_STRIDE*c+ST_TX_END]  = tx_end_hit[c] &&
                                            !q.cmd[CH_STRIDE*c+CMD_TX];
    assign dma_ev[CH_STRIDE*c+ST_RX_END]  = rx_dma_ack[c] && rx_dma_last[c] &&
                                            !q.cmd[CH_STRIDE*c+CMD_RX];
    assign dma_ev[CH_STRIDE*c+ST_RX_FULL] = rx_full_hit[c] &&
                                            !q.cmd[CH_STRIDE*c+CMD_RX];
    assign dma_ev[CH_STRIDE*c+3]          = 1'b0;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d     = q;
    d.cmd = 8'h00;

    // Read channel
    if (q.rval && rready) begin
      d.rval = 1'b0;
    end
    if (ar_hs) begin
      d.rval  = 1'b1;
      d.rresp = is_map(ridx) ? RESP_OKAY : RESP_SLVERR;
      d.rdat  = '0;
      case (ridx)
        IDX_GSTAT: begin
          d.rdat[GS_PORT] = port_any;
          d.rdat[GS_DMA]  = dma_any;
        end
        IDX_PMASK_L: d.rdat[7:0] = {5'h00, q.port_mask[10:8]};
        IDX_PMASK_H: d.rdat[7:0] = {1'b1, q.port_mask[6], 3'h7, q.port_mask[2:0]};
        IDX_PEV_L: begin
          d.rdat[7:0]        = {5'h00, q.port_flag[10:8]};
          d.port_flag[10:8]  = 3'h0;
        end
        IDX_PEV_H: begin
          d.rdat[7:0]        = {1'b0, q.port_flag[6], 3'h0, q.port_flag[2:0]};
          d.port_flag[6]     = 1'b0;
          d.port_flag[2:0]   = 3'h0;
        end
        IDX_CMD:    d.rdat[7:0] = q.cmd;
        IDX_DSTAT: begin
          d.rdat[7:0] = q.dma_stat;
          d.dma_stat  = 8'h00;
        end
        IDX_DMASK:  d.rdat[7:0]  = q.dma_mask;
        IDX_RXSZ_A: d.rdat[15:0] = q.rx_size[0];
        IDX_RXSZ_B: d.rdat[15:0] = q.rx_size[1];
        IDX_TXBC_A: d.rdat[15:0] = q.tx_total[0];
        IDX_TXBC_B: d.rdat[15:0] = q.tx_total[1];
        IDX_CFG:    d.rdat[CFG_CHK_DIS] = q.chk_dis;
        default: begin
        end
      endcase
    end
    d.arrdy = !d.rval;

    // Write channels, either order
    if (aw_hs) begin
      d.aw_have = 1'b1;
      d.widx    = awaddr[ADDR_W-1:IDX_LSB];
    end
    if (w_hs) begin
      d.w_have = 1'b1;
      d.wdat   = wdata;
      d.wstb   = wstrb;
    end
    if (q.bval && bready) begin
      d.bval = 1'b0;
    end
    if (do_wr) begin
      d.aw_have = 1'b0;
      d.w_have  = 1'b0;
      d.bval    = 1'b1;
      d.bresp   = is_map(q.widx) ? RESP_OKAY : RESP_SLVERR;
      if (q.wstb[0]) begin
        case (q.widx)
          IDX_PMASK_L: d.port_mask[10:8] = q.wdat[2:0];
          IDX_PMASK_H: begin
            d.port_mask[6]   = q.wdat[6];
            d.port_mask[2:0] = q.wdat[2:0];
          end
          IDX_CMD:   d.cmd      = q.wdat[7:0] & CMD_BITS;
          IDX_DMASK: d.dma_mask = q.wdat[7:0] & DMASK_BITS;
          IDX_CFG:   d.chk_dis  = q.wdat[CFG_CHK_DIS];
          default: begin
          end
        endcase
      end
      case (q.widx)
        IDX_RXSZ_A: d.rx_size[0]  = lane16(q.rx_size[0], q.wdat[15:0], q.wstb[1:0]);
        IDX_RXSZ_B: d.rx_size[1]  = lane16(q.rx_size[1], q.wdat[15:0], q.wstb[1:0]);
        IDX_TXBC_A: d.tx_total[0] = lane16(q.tx_total[0], q.wdat[15:0], q.wstb[1:0]);
        IDX_TXBC_B: d.tx_total[1] = lane16(q.tx_total[1], q.wdat[15:0], q.wstb[1:0]);
        default: begin
        end
      endcase
    end
    d.awrdy = !d.aw_have && !d.bval;
    d.wrdy  = !d.w_have && !d.bval;

    d.primed    = 1'b1;
    d.pin_prev  = gpp_pin_in;
    d.port_flag = d.port_flag | port_ev;

    for (int c = 0; c < 2; c++) begin
      if (q.cmd[CH_STRIDE*c+CMD_RX]) begin
        d.rx_cnt[c] = 16'h0000;
      end else if (rx_dma_ack[c]) begin
        d.rx_cnt[c] = (rx_full_hit[c] || rx_dma_last[c]) ? 16'h0000 :
                      q.rx_cnt[c] + 16'h0001;
      end
      if (q.cmd[CH_STRIDE*c+CMD_TX]) begin
        d.tx_cnt[c] = 16'h0000;
      end else if (tx_dma_ack[c]) begin
        d.tx_cnt[c] = tx_end_hit[c] ? 16'h0000 : q.tx_cnt[c] + 16'h0001;
      end
    end

    d.dma_stat = d.dma_stat | dma_ev;
    d.irq = (|d.port_flag) || (|(d.dma_stat & ~d.dma_mask));
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= ST_RST;
    end else if (ce) begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign awready          = q.awrdy;
  assign wready           = q.wrdy;
  assign bvalid           = q.bval;
  assign bresp            = q.bresp;
  assign arready          = q.arrdy;
  assign rvalid           = q.rval;
  assign rresp            = q.rresp;
  assign rdata            = q.rdat;
  assign rx_path_reset[0] = q.cmd[CMD_RX];
  assign rx_path_reset[1] = q.cmd[CH_STRIDE+CMD_RX];
  assign tx_path_reset[0] = q.cmd[CMD_TX];
  assign tx_path_reset[1] = q.cmd[CH_STRIDE+CMD_TX];
  assign irq              = q.irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_rd(logic [4:0] i);
    ce && ar_hs && ridx == i;
  endsequence

  sequence s_wr(logic [4:0] i);
    ce && do_wr && q.widx == i && q.wstb[0];
  endsequence

  sequence s_cmd_rx;
    s_wr(IDX_CMD) ##0 q.wdat[CMD_RX];
  endsequence

  property p_port_set;
    ce && port_ev[0] |=> q.port_flag[0];
  endproperty
  a_port_set: assert property (p_port_set) else $error("pin event lost");

  property p_port_rdclr;
    s_rd(IDX_PEV_L) ##0 port_ev[10:8] == 3'h0 |=> q.port_flag[10:8] == 3'h0;
  endproperty
  a_port_rdclr: assert property (p_port_rdclr) else $error("port flags not cleared");

  property p_low_fmt;
    s_rd(IDX_PEV_L) |=> rvalid && rdata[31:3] == 29'h0000_0000;
  endproperty
  a_low_fmt: assert property (p_low_fmt) else $error("low port status layout");

  property p_high_fmt;
    s_rd(IDX_PEV_H) |=> rvalid && (rdata & ~32'h0000_0047) == 32'h0000_0000;
  endproperty
  a_high_fmt: assert property (p_high_fmt) else $error("high port status layout");

  property p_cmd_pulse;
    s_cmd_rx |=> rx_path_reset[0] and
                 (ce |=> !rx_path_reset[0] && q.rx_cnt[0] == 16'h0000);
  endproperty
  a_cmd_pulse: assert property (p_cmd_pulse) else $error("reset command pulse");

  property p_cmd_zero;
    s_wr(IDX_CMD) ##0 !q.wdat[CMD_TX] |=> !tx_path_reset[0];
  endproperty
  a_cmd_zero: assert property (p_cmd_zero) else $error("zero command acted");

  property p_dstat_fmt;
    s_rd(IDX_DSTAT) |=> rdata[31:8] == 24'h00_0000 && !rdata[7] && !rdata[3];
  endproperty
  a_dstat_fmt: assert property (p_dstat_fmt) else $error("dma status layout");

  property p_masked_rec;
    ce && dma_ev[0] && q.dma_mask[0] |=> q.dma_stat[0];
  endproperty
  a_masked_rec: assert property (p_masked_rec) else $error("masked event lost");

  property p_unmask_irq;
    q.dma_stat[0] && !q.dma_mask[0] |-> irq;
  endproperty
  a_unmask_irq: assert property (p_unmask_irq) else $error("unmasked event silent");

  property p_rx_full;
    ce && rx_dma_ack[1] && !q.chk_dis && q.rx_size[1] == 16'h0004 &&
    q.rx_cnt[1] == 16'h0003 && !q.cmd[CH_STRIDE+CMD_RX]
    |=> q.dma_stat[CH_STRIDE+ST_RX_FULL];
  endproperty
  a_rx_full: assert property (p_rx_full) else $error("buffer full missed");

  property p_chk_off;
    ce && q.chk_dis && !q.dma_stat[ST_RX_FULL] |=> !q.dma_stat[ST_RX_FULL];
  endproperty
  a_chk_off: assert property (p_chk_off) else $error("buffer full while disabled");

  property p_rx_end;
    ce && rx_dma_ack[1] && rx_dma_last[1] && !q.cmd[CH_STRIDE+CMD_RX]
    |=> q.dma_stat[CH_STRIDE+ST_RX_END];
  endproperty
  a_rx_end: assert property (p_rx_end) else $error("receive end missed");

  property p_tx_end;
    ce && tx_dma_ack[0] && q.tx_total[0] == 16'h0003 &&
    q.tx_cnt[0] == 16'h0002 && !q.cmd[CMD_TX] |=> q.dma_stat[ST_TX_END];
  endproperty
  a_tx_end: assert property (p_tx_end) else $error("transmit end missed");

  property p_mask_quiet;
    q.port_flag == 11'h000 && (q.dma_stat & ~q.dma_mask) == 8'h00 |-> !irq;
  endproperty
  a_mask_quiet: assert property (p_mask_quiet) else $error("irq without cause");

  property p_mask_rst;
    !$past(rst_n) |-> q.dma_mask == RST_DMASK && !irq;
  endproperty
  a_mask_rst: assert property (p_mask_rst) else $error("dma mask reset value");

  property p_pmask_off;
    ce && q.port_mask[1] && !q.port_flag[1] |=> !q.port_flag[1];
  endproperty
  a_pmask_off: assert property (p_pmask_off) else $error("masked pin flagged");

  property p_dma_sum;
    s_rd(IDX_GSTAT) |=> rdata[GS_DMA] == $past(dma_any);
  endproperty
  a_dma_sum: assert property (p_dma_sum) else $error("dma summary wrong");

  property p_port_sum;
    s_rd(IDX_GSTAT) |=> rdata[GS_PORT] == $past(port_any);
  endproperty
  a_port_sum: assert property (p_port_sum) else $error("port summary wrong");

  property p_dstat_clr;
    s_rd(IDX_DSTAT) ##0 dma_ev == 8'h00 |=> q.dma_stat == 8'h00;
  endproperty
  a_dstat_clr: assert property (p_dstat_clr) else $error("dma status not cleared");

  property p_port_irq;
    port_any |-> irq;
  endproperty
  a_port_irq: assert property (p_port_irq) else $error("port event silent");

endmodule

`default_nettype wire

// *** verif/gdis_dma_model.sv ***
// Purpose: Far side DMA mover, one ack strobe per byte
// Assumes: Commanded by the bench after a rising edge
// Notes:   Slow mode leaves three idle cycles between bytes
`timescale 1ns/10ps
`default_nettype none

module gdis_dma_model (
  // Clock and command
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic       ch,
  input  wire logic       tx,
  input  wire logic       lst,
  input  wire logic       slow,
  input  wire logic [3:0] n,
  // Byte strobes
  output logic [1:0]      rx_ack,
  output logic [1:0]      rx_last,
  output logic [1:0]      tx_ack,
  output logic            done
);
  initial begin
    rx_ack = 2'h0;
    rx_last = 2'h0;
    tx_ack = 2'h0;
    done = 1'b0;
    forever begin
      @(posedge clk);
      if (go) begin
        for (int k = 0; k < n; k++) begin
          rx_ack <= tx ? 2'h0 : 2'h1 << ch;
          rx_last <= (!tx && lst && k == n - 1) ? 2'h1 << ch : 2'h0;
          tx_ack <= tx ? 2'h1 << ch : 2'h0;
          @(posedge clk);
          if (slow) begin
            rx_ack <= 2'h0;
            rx_last <= 2'h0;
            tx_ack <= 2'h0;
            repeat (3) @(posedge clk);
          end
        end
        rx_ack <= 2'h0;
        rx_last <= 2'h0;
        tx_ack <= 2'h0;
        done <= 1'b1;
        @(posedge clk);
        done <= 1'b0;
      end
    end
  end
endmodule

`default_nettype wire

// *** verif/tb.sv ***
// Purpose: Self-checking bench of the port and DMA event block
// Assumes: Byte address is four times the register index
// Notes:   Read and write answers are checked from queues
`timescale 1ns/10ps
`default_nettype none

module tb;
  import gdis_pkg::*;
  logic              clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic              awready, wready, bvalid, arready, rvalid, irq;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0]       wdata, rdata;
  logic [3:0]        wstrb, n;
  logic [1:0]        bresp, rresp, rx_ack, rx_last, tx_ack, rx_rst, tx_rst;
  logic [PIN_W-1:0]  pins, fl;
  logic              go, ch, tx, lst, slow, done;
  logic [33:0]       rq[$];
  logic [1:0]        bq[$];
  int                num_errors = 0, check_count = 0, cyc = 0, seed = 34;
  int                np[4] = '{0, 0, 0, 0};
  int                ep[4] = '{1, 1, 2, 1};

  gdis_top uut (.clk(clk), .rst_n(rst_n), .ce(1'b1),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .gpp_pin_in(pins), .rx_dma_ack(rx_ack), .rx_dma_last(rx_last),
    .tx_dma_ack(tx_ack), .rx_path_reset(rx_rst), .tx_path_reset(tx_rst),
    .irq(irq));

  gdis_dma_model dma (.clk(clk), .go(go), .ch(ch), .tx(tx), .lst(lst),
    .slow(slow), .n(n), .rx_ack(rx_ack), .rx_last(rx_last),
    .tx_ack(tx_ack), .done(done));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [4:0] i, input logic [31:0] d,
                    input logic [1:0] r = RESP_OKAY);
    bq.push_back(r);
    awaddr <= {i, 2'h0};
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [4:0] i, input logic [31:0] e,
                    input logic [1:0] r = RESP_OKAY);
    rq.push_back({r, e});
    araddr <= {i, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic irqchk(input logic e);
    @(negedge clk);
    chk("irq", e, irq);
    @(posedge clk);
  endtask

  task automatic pin(input logic [PIN_W-1:0] v, input logic [PIN_W-1:0] m);
    fl = fl | ((pins ^ v) & m);
    pins <= v;
    repeat (2) @(posedge clk);
  endtask

  task automatic mv(input logic c, input logic t, input logic l, input logic [3:0] k);
    ch <= c;
    tx <= t;
    lst <= l;
    n <= k;
    slow <= 1'($random(seed));
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    do @(posedge clk); while (!done);
  endtask

  // Answer monitor, path reset pulse count, timeout
  always @(posedge clk) begin
    cyc++;
    if (bvalid && bready) chk("bresp", bq.pop_front(), bresp);
    if (rvalid && rready) chk("rdata", rq.pop_front(), {rresp, rdata});
    for (int k = 0; k < 2; k++) begin
      np[k] += rx_rst[k];
      np[k + 2] += tx_rst[k];
    end
    if (cyc == 20000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {go, ch, tx, lst, slow} = 5'h0;
    {awaddr, araddr, wdata, wstrb, n} = '0;
    pins = '0;
    fl = '0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(IDX_PEV_L, 32'h0);
    rd(IDX_PEV_H, 32'h0);
    rd(IDX_DSTAT, 32'h0);
    rd(IDX_DMASK, 32'h0000_0077);
    rd(IDX_CMD, 32'h0);
    rd(5'h1f, 32'h0, RESP_SLVERR);
    wr(5'h1f, 32'h0000_00ff, RESP_SLVERR);
    $display("reset values done");
    wr(IDX_PMASK_L, 32'h0);
    wr(IDX_PMASK_H, 32'h0);
    for (int i = 0; i < 6; i++) begin
      pin(11'($random(seed)), PIN_VALID);
      irqchk(|fl);
      rd(IDX_GSTAT, 32'(|fl) << GS_PORT);
      rd(IDX_PEV_L, 32'(fl[10:8]));
      rd(IDX_PEV_H, {25'h0, fl[6], 3'h0, fl[2:0]});
      fl = '0;
      rd(IDX_PEV_L, 32'h0);
    end
    wr(IDX_PMASK_H, 32'h0000_0001);
    pin(pins ^ 11'h001, 11'h000);
    rd(IDX_PEV_H, 32'h0);
    $display("port events done");
    wr(IDX_DMASK, 32'h0000_00ff);
    rd(IDX_DMASK, 32'h0000_0077);
    wr(IDX_TXBC_A, 32'h0000_0003);
    mv(1'b0, 1'b1, 1'b0, 4'h3);
    irqchk(1'b0);
    rd(IDX_GSTAT, 32'h0000_0040);
    wr(IDX_DMASK, 32'h0000_0076);
    irqchk(1'b1);
    rd(IDX_DSTAT, 32'h0000_0001);
    rd(IDX_DSTAT, 32'h0);
    irqchk(1'b0);
    wr(IDX_RXSZ_B, 32'h0000_0004);
    mv(1'b1, 1'b0, 1'b0, 4'h4);
    mv(1'b1, 1'b0, 1'b1, 4'h2);
    rd(IDX_DSTAT, 32'h0000_0060);
    wr(IDX_CFG, 32'h0000_0001);
    wr(IDX_RXSZ_A, 32'h0000_0004);
    mv(1'b0, 1'b0, 1'b0, 4'h4);
    rd(IDX_DSTAT, 32'h0);
    $display("dma events done");
    wr(IDX_CMD, 32'h0000_0008);
    mv(1'b0, 1'b1, 1'b0, 4'h2);
    wr(IDX_CMD, 32'h0000_00a2);
    mv(1'b0, 1'b1, 1'b0, 4'h1);
    rd(IDX_DSTAT, 32'h0000_0001);
    wr(IDX_CMD, 32'h0000_0008);
    mv(1'b0, 1'b1, 1'b0, 4'h2);
    rd(IDX_DSTAT, 32'h0);
    rd(IDX_CMD, 32'h0);
    for (int k = 0; k < 4; k++) chk("path_reset", ep[k], np[k]);
    $display("reset commands done");
    tally_and_finish();
  end
endmodule

`default_nettype wire
